// File: rtl/ast_axil_slave.sv
// axi4-lite slave front end: register write strobe and read mux port
`timescale 1ns/100ps
`default_nettype none
module ast_axil_slave
    import ast_pkg::*;
(
    input wire logic i_clock, // system clock
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_awvalid, // write address valid
    output logic o_awready, // write address ready
    input wire logic [AST_BUS_AW-1:0] i_awaddr, // write address
    input wire logic i_wvalid, // write data valid
    output logic o_wready, // write data ready
    input wire logic [AST_BUS_DW-1:0] i_wdata, // write data
    input wire logic [3:0] i_wstrb, // write byte enables
    output logic o_bvalid, // write response valid
    input wire logic i_bready, // write response ready
    output logic [1:0] o_bresp, // write response
    input wire logic i_arvalid, // read address valid
    output logic o_arready, // read address ready
    input wire logic [AST_BUS_AW-1:0] i_araddr, // read address
    output logic o_rvalid, // read data valid
    input wire logic i_rready, // read data ready
    output logic [AST_BUS_DW-1:0] o_rdata, // read data
    output logic [1:0] o_rresp, // read response
    output logic o_wr_en, // register write strobe
    output logic [AST_BUS_AW-1:0] o_wr_addr, // register write address
    output logic [AST_BUS_DW-1:0] o_wr_data, // register write data
    output logic [3:0] o_wr_strb, // register byte enables
    output logic [AST_BUS_AW-1:0] o_rd_addr, // register read address
    input wire logic [AST_BUS_DW-1:0] i_rd_data // register read data
);
    logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
    logic [AST_BUS_AW-1:0] awaddr_ff;
    logic [AST_BUS_DW-1:0] wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    wire aw_hs = i_awvalid & o_awready;
    wire w_hs = i_wvalid & o_wready;
    wire ar_hs = i_arvalid & o_arready;
    wire do_wr = aw_held_ff & w_held_ff & ~bvalid_ff;
    // each write channel is taken once, in either order
    assign o_awready = ~aw_held_ff;
    assign o_wready = ~w_held_ff;
    assign o_arready = ~rvalid_ff;
    assign o_bvalid = bvalid_ff;
    assign o_rvalid = rvalid_ff;
    assign o_bresp = AST_RESP_OKAY;
    assign o_rresp = AST_RESP_OKAY;
    assign o_rdata = rdata_ff;
    assign o_wr_en = do_wr;
    assign o_wr_addr = awaddr_ff;
    assign o_wr_data = wdata_ff;
    assign o_wr_strb = wstrb_ff;
    assign o_rd_addr = i_araddr;
    // write side: hold both halves, commit, then answer
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else begin
            if (aw_hs) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= i_awaddr;
            end
            if (w_hs) begin
                w_held_ff <= 1'b1;
                wdata_ff <= i_wdata;
                wstrb_ff <= i_wstrb;
            end
            if (do_wr) begin
                bvalid_ff <= 1'b1;
            end else if (bvalid_ff && i_bready) begin
                bvalid_ff <= 1'b0;
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
            end
        end
    end
    // read side: data sampled at the address handshake
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
        end else if (ar_hs) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= i_rd_data;
        end else if (i_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: rtl/ast_pkg.sv
// constants, field layout and types shared by the async sram controller
package ast_pkg;
    // register bus geometry
    localparam int unsigned AST_BUS_AW = 8;
    localparam int unsigned AST_BUS_DW = 32;
    // sram port geometry: 16384 words of 8 bits
    localparam int unsigned AST_SRAM_AW = 14;
    localparam int unsigned AST_SRAM_DW = 8;
    localparam int unsigned AST_SRAM_WORDS = 16384;
    // clock: one i_clock cycle is one half-period of the fast clock
    localparam int unsigned AST_CLK_PERIOD_NS = 8;
    // register byte offsets
    localparam logic [7:0] AST_OFS_CTRL = 8'h00;
    localparam logic [7:0] AST_OFS_ADDR = 8'h04;
    localparam logic [7:0] AST_OFS_WDATA = 8'h08;
    localparam logic [7:0] AST_OFS_CMD = 8'h0C;
    localparam logic [7:0] AST_OFS_STATUS = 8'h10;
    // control word fields
    localparam int unsigned AST_CTRL_MODE_LSB = 0;
    localparam int unsigned AST_CTRL_GATE_BIT = 2;
    localparam int unsigned AST_CTRL_DIV_LSB = 4;
    localparam int unsigned AST_CTRL_START_LSB = 8;
    localparam int unsigned AST_CTRL_LEN_LSB = 16;
    localparam int unsigned AST_CTRL_SOFT_BIT = 31;
    // command and status fields
    localparam int unsigned AST_CMD_WR_BIT = 0;
    localparam int unsigned AST_CMD_RD_BIT = 1;
    localparam int unsigned AST_STAT_BUSY_BIT = 0;
    localparam int unsigned AST_STAT_POS_BIT = 1;
    localparam int unsigned AST_STAT_RDATA_LSB = 8;
    // access modes
    localparam logic [1:0] AST_MODE_POS = 2'h0;
    localparam logic [1:0] AST_MODE_SAME = 2'h1;
    localparam logic [1:0] AST_MODE_GATE = 2'h2;
    // control reset values: divide 4, start 4 halves, length 2 halves
    localparam logic [3:0] AST_RST_DIV = 4'h4;
    localparam logic [7:0] AST_RST_START = 8'h04;
    localparam logic [7:0] AST_RST_LEN = 8'h02;
    localparam logic AST_RST_GATE = 1'b1;
    localparam logic [31:0] AST_RST_CTRL = (32'(AST_RST_LEN) << AST_CTRL_LEN_LSB)
        | (32'(AST_RST_START) << AST_CTRL_START_LSB) | (32'(AST_RST_DIV) << AST_CTRL_DIV_LSB)
        | (32'(AST_RST_GATE) << AST_CTRL_GATE_BIT) | 32'(AST_MODE_POS);
    // axi responses
    localparam logic [1:0] AST_RESP_OKAY = 2'h0;
    // sequencer states
    typedef enum logic [3:0] {
        AST_IDLE = 4'b0001,
        AST_PRE = 4'b0010,
        AST_ACT = 4'b0100,
        AST_POST = 4'b1000
    } ast_state_e;
endpackage

// File: rtl/ast_sram_ctrl.sv
// async sram controller with positioned write strobe behind axi4-lite
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - strobe placed on fast-clock half-period steps
// - positioned strobe needs divide factor above one
// - strobe begins at start, lasts length
// - divide four, start four, length two: mid-cycle quarter strobe
// - half cycle setup, quarter cycle hold
// - same-rate clock uses several successive accesses
// - gated write enable in chosen half
// - 8-bit data, 16384 words, cs we oe
// - global reset restores sequencing and registers
// - global reset leaves memory contents untouched
// - active-high reset from pin or expression
// - current reset state exported for sub-blocks
module ast_sram_ctrl
    import ast_pkg::*;
(
    input wire logic i_clock, // one cycle per fast-clock half-period
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_greset, // external global reset pin, active high
    output logic o_reset_state, // current global reset state
    input wire logic i_s_axi_awvalid, // axi write address valid
    output logic o_s_axi_awready, // axi write address ready
    input wire logic [AST_BUS_AW-1:0] i_s_axi_awaddr, // axi write address
    input wire logic i_s_axi_wvalid, // axi write data valid
    output logic o_s_axi_wready, // axi write data ready
    input wire logic [AST_BUS_DW-1:0] i_s_axi_wdata, // axi write data
    input wire logic [3:0] i_s_axi_wstrb, // axi byte enables
    output logic o_s_axi_bvalid, // axi write response valid
    input wire logic i_s_axi_bready, // axi write response ready
    output logic [1:0] o_s_axi_bresp, // axi write response
    input wire logic i_s_axi_arvalid, // axi read address valid
    output logic o_s_axi_arready, // axi read address ready
    input wire logic [AST_BUS_AW-1:0] i_s_axi_araddr, // axi read address
    output logic o_s_axi_rvalid, // axi read data valid
    input wire logic i_s_axi_rready, // axi read data ready
    output logic [AST_BUS_DW-1:0] o_s_axi_rdata, // axi read data
    output logic [1:0] o_s_axi_rresp, // axi read response
    output logic [AST_SRAM_AW-1:0] o_sram_addr, // sram address
    output logic [AST_SRAM_DW-1:0] o_sram_data, // sram data out
    input wire logic [AST_SRAM_DW-1:0] i_sram_data, // sram data in
    output logic o_sram_data_oe_n, // data drive enable, low drives
    output logic o_sram_cs_n, // chip select, active low
    output logic o_sram_we_n, // write enable, active low
    output logic o_sram_oe_n // output enable, active low
);
    // byte-lane merge of a bus write into a register word
    function automatic logic [31:0] ast_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction

    logic [31:0] ctrl_ff;
    logic [AST_SRAM_AW-1:0] reg_addr_ff;
    logic [AST_SRAM_DW-1:0] reg_wdata_ff, rdata_ff;
    logic pend_wr_ff, pend_rd_ff, op_rd_ff;
    logic [1:0] op_mode_ff;
    ast_state_e state_ff, nxt_state;
    logic [AST_SRAM_AW-1:0] sram_addr_ff;
    logic [AST_SRAM_DW-1:0] sram_data_ff;
    logic cs_n_ff, we_n_ff, oe_n_ff, data_oe_n_ff;
    logic wr_en;
    logic [AST_BUS_AW-1:0] wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0] wr_strb;
    logic [7:0] cnt;
    logic sys_end, win_nxt, first_nxt;

    // global reset: external pin or internal soft-reset expression
    // the bus slave stays out of it so a soft-reset write is still answered
    wire grst = i_greset | ctrl_ff[AST_CTRL_SOFT_BIT];
    assign o_reset_state = grst;

    // control fields
    wire [1:0] ctrl_mode = ctrl_ff[AST_CTRL_MODE_LSB +: 2];
    wire ctrl_gate = ctrl_ff[AST_CTRL_GATE_BIT];
    wire [3:0] ctrl_div = ctrl_ff[AST_CTRL_DIV_LSB +: 4];
    wire [7:0] ctrl_start = ctrl_ff[AST_CTRL_START_LSB +: 8];
    wire [7:0] ctrl_len = ctrl_ff[AST_CTRL_LEN_LSB +: 8];

    // positioned strobe only with a real divide, else repeated access
    wire pos_ok = (ctrl_div > 4'h1);
    wire [1:0] eff_mode = (ctrl_mode == AST_MODE_SAME) ? AST_MODE_SAME :
                          (ctrl_mode == AST_MODE_GATE) ? AST_MODE_GATE :
                          pos_ok ? AST_MODE_POS : AST_MODE_SAME;

    // register decode
    wire is_idle = (state_ff == AST_IDLE);
    wire busy = pend_wr_ff | pend_rd_ff | ~is_idle;
    wire wr_ctrl = wr_en && (wr_addr == AST_OFS_CTRL);
    wire wr_addr_reg = wr_en && (wr_addr == AST_OFS_ADDR);
    wire wr_data_reg = wr_en && (wr_addr == AST_OFS_WDATA);
    wire wr_cmd = wr_en && (wr_addr == AST_OFS_CMD) && wr_strb[0] && !busy;
    wire [31:0] new_addr = ast_merge(32'(reg_addr_ff), wr_data, wr_strb);
    wire [31:0] new_wdata = ast_merge(32'(reg_wdata_ff), wr_data, wr_strb);
    wire [31:0] status_w = (32'(rdata_ff) << AST_STAT_RDATA_LSB)
                         | (32'(pos_ok) << AST_STAT_POS_BIT) | (32'(busy) << AST_STAT_BUSY_BIT);

    // read mux, unmapped offsets read zero
    assign rd_data = (rd_addr == AST_OFS_CTRL) ? ctrl_ff :
                     (rd_addr == AST_OFS_ADDR) ? 32'(reg_addr_ff) :
                     (rd_addr == AST_OFS_WDATA) ? 32'(reg_wdata_ff) :
                     (rd_addr == AST_OFS_STATUS) ? status_w : 32'h0000_0000;

    // commands start only on a system cycle boundary
    wire go_wr = is_idle & pend_wr_ff & sys_end;
    wire go_rd = is_idle & pend_rd_ff & ~pend_wr_ff & sys_end;
    wire go = go_wr | go_rd;
    wire [1:0] nxt_op_mode = go ? eff_mode : op_mode_ff;
    wire nxt_op_rd = go ? go_rd : op_rd_ff;

    // sequencer: pre-hold, access, post-hold cycles per mode
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            AST_IDLE: begin
                if (go) begin
                    nxt_state = (eff_mode == AST_MODE_SAME) ? AST_PRE : AST_ACT;
                end
            end
            AST_PRE: begin
                if (sys_end) begin
                    nxt_state = AST_ACT;
                end
            end
            AST_ACT: begin
                if (sys_end) begin
                    nxt_state = (op_mode_ff == AST_MODE_POS) ? AST_IDLE : AST_POST;
                end
            end
            AST_POST: begin
                if (sys_end) begin
                    nxt_state = AST_IDLE;
                end
            end
            default: begin
                nxt_state = AST_IDLE;
            end
        endcase
    end

    // where the write strobe falls inside the access cycle
    // decoded one half-period ahead so the registered pins change on the edge
    wire we_slot = (nxt_op_mode == AST_MODE_POS) ? win_nxt :
                   (nxt_op_mode == AST_MODE_GATE) ? (first_nxt != ctrl_gate) :
                   1'b1;
    wire nxt_active = (nxt_state != AST_IDLE);
    wire nxt_cs_n = ~nxt_active;
    wire nxt_oe_n = ~(nxt_op_rd & nxt_active);
    wire nxt_we_n = ~(~nxt_op_rd & (nxt_state == AST_ACT) & we_slot);
    wire nxt_data_oe_n = ~(~nxt_op_rd & nxt_active);
    // read data is taken at the closing edge while oe is still low
    wire capture = op_rd_ff & sys_end &
                   (((state_ff == AST_ACT) & (op_mode_ff == AST_MODE_POS)) | (state_ff == AST_POST));

    // software registers; global reset restores them
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_ff <= AST_RST_CTRL;
            reg_addr_ff <= '0;
            reg_wdata_ff <= '0;
        end else if (grst) begin
            ctrl_ff <= AST_RST_CTRL;
            reg_addr_ff <= '0;
            reg_wdata_ff <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= ast_merge(ctrl_ff, wr_data, wr_strb);
            end
            if (wr_addr_reg) begin
                reg_addr_ff <= new_addr[AST_SRAM_AW-1:0];
            end
            if (wr_data_reg) begin
                reg_wdata_ff <= new_wdata[AST_SRAM_DW-1:0];
            end
        end
    end

    // pending commands and latched operation
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_wr_ff <= 1'b0;
            pend_rd_ff <= 1'b0;
            op_rd_ff <= 1'b0;
            op_mode_ff <= AST_MODE_POS;
            state_ff <= AST_IDLE;
            rdata_ff <= '0;
        end else if (grst) begin
            pend_wr_ff <= 1'b0;
            pend_rd_ff <= 1'b0;
            op_rd_ff <= 1'b0;
            op_mode_ff <= AST_MODE_POS;
            state_ff <= AST_IDLE;
            rdata_ff <= '0;
        end else begin
            pend_wr_ff <= (pend_wr_ff & ~go_wr) | (wr_cmd & wr_data[AST_CMD_WR_BIT]);
            pend_rd_ff <= (pend_rd_ff & ~go_rd) | (wr_cmd & wr_data[AST_CMD_RD_BIT]);
            op_rd_ff <= nxt_op_rd;
            op_mode_ff <= nxt_op_mode;
            state_ff <= nxt_state;
            if (capture) begin
                rdata_ff <= i_sram_data;
            end
        end
    end

    // sram pins: all registered, idle during reset, memory untouched
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sram_addr_ff <= '0;
            sram_data_ff <= '0;
            cs_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            data_oe_n_ff <= 1'b1;
        end else if (grst) begin
            sram_addr_ff <= '0;
            sram_data_ff <= '0;
            cs_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            data_oe_n_ff <= 1'b1;
        end else begin
            if (go) begin
                sram_addr_ff <= reg_addr_ff;
                sram_data_ff <= reg_wdata_ff;
            end
            cs_n_ff <= nxt_cs_n;
            we_n_ff <= nxt_we_n;
            oe_n_ff <= nxt_oe_n;
            data_oe_n_ff <= nxt_data_oe_n;
        end
    end

    assign o_sram_addr = sram_addr_ff;
    assign o_sram_data = sram_data_ff;
    assign o_sram_cs_n = cs_n_ff;
    assign o_sram_we_n = we_n_ff;
    assign o_sram_oe_n = oe_n_ff;
    assign o_sram_data_oe_n = data_oe_n_ff;

    // register bus front end
    ast_axil_slave u_bus (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_awvalid(i_s_axi_awvalid),
        .o_awready(o_s_axi_awready),
        .i_awaddr(i_s_axi_awaddr),
        .i_wvalid(i_s_axi_wvalid),
        .o_wready(o_s_axi_wready),
        .i_wdata(i_s_axi_wdata),
        .i_wstrb(i_s_axi_wstrb),
        .o_bvalid(o_s_axi_bvalid),
        .i_bready(i_s_axi_bready),
        .o_bresp(o_s_axi_bresp),
        .i_arvalid(i_s_axi_arvalid),
        .o_arready(o_s_axi_arready),
        .i_araddr(i_s_axi_araddr),
        .o_rvalid(o_s_axi_rvalid),
        .i_rready(i_s_axi_rready),
        .o_rdata(o_s_axi_rdata),
        .o_rresp(o_s_axi_rresp),
        .o_wr_en(wr_en),
        .o_wr_addr(wr_addr),
        .o_wr_data(wr_data),
        .o_wr_strb(wr_strb),
        .o_rd_addr(rd_addr),
        .i_rd_data(rd_data)
    );

    // half-period framing of each system cycle
    ast_strobe_timer u_timer (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_restart(grst),
        .i_div(ctrl_div),
        .i_start(ctrl_start),
        .i_len(ctrl_len),
        .o_cnt(cnt),
        .o_last(sys_end),
        .o_win_nxt(win_nxt),
        .o_first_nxt(first_nxt)
    );

    // checks on the pin sequence
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    sequence seq_quarter_strobe;
        !o_sram_we_n ##1 !o_sram_we_n ##1 o_sram_we_n;
    endsequence

    AST_WE_NEEDS_CS: assert property (!o_sram_we_n |-> !o_sram_cs_n && o_sram_oe_n && !o_sram_data_oe_n)
        else $error("write strobe without chip select or with output enable");
    AST_WE_IN_WINDOW: assert property (!o_sram_we_n && op_mode_ff == AST_MODE_POS
        |-> cnt >= ctrl_start && {1'b0, cnt} < {1'b0, ctrl_start} + {1'b0, ctrl_len})
        else $error("positioned strobe outside its window");
    AST_POS_NEEDS_DIV: assert property ($fell(o_sram_cs_n) && op_mode_ff == AST_MODE_POS |-> pos_ok)
        else $error("positioned strobe with undivided clock");
    AST_QUARTER: assert property ($fell(o_sram_we_n) && op_mode_ff == AST_MODE_POS && ctrl_div == 4'h4
        && ctrl_start == 8'h04 && ctrl_len == 8'h02 |-> cnt == 8'h04 ##0 seq_quarter_strobe)
        else $error("example strobe not mid-cycle quarter");
    AST_ADDR_HELD: assert property (!o_sram_cs_n && !$past(o_sram_cs_n) |-> $stable(o_sram_addr))
        else $error("address moved during access");
    AST_SAME_PRE: assert property ($fell(o_sram_we_n) && op_mode_ff == AST_MODE_SAME
        |-> !$past(o_sram_cs_n) && cnt == 8'h00)
        else $error("same-rate write without hold cycle before");
    AST_GATE_HALF: assert property (!o_sram_we_n && op_mode_ff == AST_MODE_GATE
        |-> (cnt < {4'h0, ctrl_div}) != ctrl_gate)
        else $error("gated strobe in wrong half");
    AST_CS_AT_EDGE: assert property ($fell(o_sram_cs_n) |-> cnt == 8'h00)
        else $error("access not aligned to system edge");
    AST_GRST: assert property (grst |=> state_ff == AST_IDLE && o_sram_cs_n && o_sram_we_n
        && ctrl_ff[AST_CTRL_SOFT_BIT] == 1'b0)
        else $error("global reset did not restore idle state");
    AST_RST_OUT: assert property (i_greset |-> o_reset_state)
        else $error("reset state not exported");

    // checks on read strobes, held data, the end of an access and the clearing by global reset
    AST_RD_OE: assert property (!o_sram_oe_n |-> !o_sram_cs_n && o_sram_we_n && o_sram_data_oe_n)
        else $error("read strobe without select or with drive");
    AST_DATA_HELD: assert property (!o_sram_cs_n && !$past(o_sram_cs_n) |-> $stable(o_sram_data))
        else $error("write data moved during access");
    AST_END_RELEASE: assert property ($rose(o_sram_cs_n) |-> o_sram_we_n && o_sram_oe_n && o_sram_data_oe_n)
        else $error("strobe still active after deselect");
    AST_RST_CLEAR: assert property (o_reset_state |=> cnt == 8'h00 && !pend_wr_ff && !pend_rd_ff && o_sram_oe_n)
        else $error("global reset left sequencing active");
endmodule
`default_nettype wire

// File: rtl/ast_strobe_timer.sv
// half-period counter that frames the system cycle and the strobe window
`timescale 1ns/100ps
`default_nettype none
module ast_strobe_timer (
    input wire logic i_clock, // one cycle per fast-clock half-period
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_restart, // global reset, restarts the count
    input wire logic [3:0] i_div, // fast cycles per system cycle
    input wire logic [7:0] i_start, // strobe start in half-periods
    input wire logic [7:0] i_len, // strobe length in half-periods
    output logic [7:0] o_cnt, // half-periods since system edge
    output logic o_last, // last half-period of the system cycle
    output logic o_win_nxt, // next half-period lies in the window
    output logic o_first_nxt // next half-period lies in first half
);
    logic [7:0] cnt_ff;
    wire [3:0] div_eff = (i_div == 4'h0) ? 4'h1 : i_div;
    wire [7:0] last_half = {3'h0, div_eff, 1'b0} - 8'h01;
    wire [7:0] nxt_cnt = (i_restart || o_last) ? 8'h00 : cnt_ff + 8'h01;
    wire [8:0] win_end = {1'b0, i_start} + {1'b0, i_len};
    // count restarts at every system edge
    assign o_cnt = cnt_ff;
    assign o_last = (cnt_ff >= last_half);
    assign o_win_nxt = (nxt_cnt >= i_start) && ({1'b0, nxt_cnt} < win_end);
    assign o_first_nxt = (nxt_cnt < {4'h0, div_eff});
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_ff <= 8'h00;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule
`default_nettype wire

// File: verification/ast_sram_ctrl_tb.sv
// self-checking bench for the async sram controller
`timescale 1ns/100ps
`default_nettype none
module ast_sram_ctrl_tb import ast_pkg::*;;
    logic i_clock = 0, i_rst_n = 0, i_greset = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [7:0] aw = 0, ar = 0, sdo, sdi;
    logic [31:0] wd = 0, rd;
    logic [13:0] sa;
    logic awr, wr, bv, arr, rv, doe, cs, we, oe, rst_st, wep = 1;
    int mismatches = 0, samples_checked = 0, csc = 0, wst = 0, wcnt = 0;
    logic [7:0] mdl [int];
    always #4 i_clock = ~i_clock;
    ast_sram_ctrl ast_sram_ctrl_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_greset(i_greset),
        .o_reset_state(rst_st), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(aw),
        .i_s_axi_wvalid(wv), .o_s_axi_wready(wr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf),
        .o_s_axi_bvalid(bv), .i_s_axi_bready(br), .o_s_axi_bresp(), .i_s_axi_arvalid(arv),
        .o_s_axi_arready(arr), .i_s_axi_araddr(ar), .o_s_axi_rvalid(rv), .i_s_axi_rready(rr),
        .o_s_axi_rdata(rd), .o_s_axi_rresp(), .o_sram_addr(sa), .o_sram_data(sdo), .i_sram_data(sdi),
        .o_sram_data_oe_n(doe), .o_sram_cs_n(cs), .o_sram_we_n(we), .o_sram_oe_n(oe));
    ast_sram_model ast_sram_model_inst (.i_addr(sa), .i_data(sdo), .o_data(sdi), .i_cs_n(cs),
        .i_we_n(we), .i_oe_n(oe));
    // strobe monitor: cycles of select before the strobe, and strobe length
    always @(posedge i_clock) begin
        csc <= cs ? 0 : csc + 1;
        wep <= we;
        if (!we) wcnt <= wcnt + 1;
        if (!we && wep) wst <= csc;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 0; tw = 0;
        @(posedge i_clock);
        awv <= 1; wv <= 1; aw <= a; wd <= d; br <= 1;
        while (!(ta && tw)) begin
            @(posedge i_clock);
            if (!ta && awr) begin ta = 1; awv <= 0; end
            if (!tw && wr) begin tw = 1; wv <= 0; end
        end
        do @(posedge i_clock); while (!bv);
        br <= 0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clock);
        arv <= 1; ar <= a; rr <= 1;
        do @(posedge i_clock); while (!arr);
        arv <= 0;
        do @(posedge i_clock); while (!rv);
        d = rd;
        rr <= 0;
    endtask
    // issue a command and poll status until the sequencer is idle
    task automatic op(input logic [31:0] c, output logic [31:0] s);
        axw(AST_OFS_CMD, c);
        repeat (20) @(posedge i_clock);
        do axr(AST_OFS_STATUS, s); while (s[AST_STAT_BUSY_BIT]);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #(8 * 40000);
        mismatches++;
        finish_test;
    end
    initial begin
        logic [31:0] v;
        logic [13:0] a;
        logic [7:0] d;
        int md, dv, st, ln, g, es, ew, w0;
        v = $urandom(21040);
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1;
        axr(AST_OFS_CTRL, v); chk(v, AST_RST_CTRL);
        axr(8'h20, v); chk(v, 0);
        // every access mode, random placement; pass four is positioned at divide one
        for (int k = 0; k < 8; k++) begin
            md = k % 4; dv = (k == 4) ? 1 : 2 + $urandom % 7; g = $urandom % 2;
            st = $urandom % (2 * dv); ln = 1 + $urandom % (2 * dv - st); a = $urandom; d = $urandom;
            axw(AST_OFS_CTRL, (ln << 16) | (st << 8) | (dv << 4) | (g << 2) | md);
            axw(AST_OFS_ADDR, 32'(a)); axw(AST_OFS_WDATA, 32'(d));
            if (md != 1 && md != 2 && dv > 1) begin es = st; ew = ln; end
            else if (md == 2) begin es = g ? dv : 0; ew = dv; end
            else begin es = 2 * dv; ew = 2 * dv; end
            w0 = wcnt;
            op(1, v); chk(wcnt - w0, ew);
            chk(wst, es);
            chk(v[1], dv > 1);
            mdl[a] = d;
            op(2, v); chk(v[15:8], mdl[a]);
        end
        @(posedge i_clock); i_greset <= 1;
        @(negedge i_clock); chk(rst_st, 1);
        @(posedge i_clock); i_greset <= 0;
        axr(AST_OFS_CTRL, v); chk(v, AST_RST_CTRL);
        axr(AST_OFS_ADDR, v); chk(v, 0);
        axw(AST_OFS_ADDR, 32'(a)); op(2, v); chk(v[15:8], mdl[a]);
        w0 = wcnt; op(1, v); chk(wcnt - w0, 2);
        chk(wst, 4);
        op(2, v); chk(v[15:8], 0);
        axw(AST_OFS_CTRL, 32'h8000_0013); axr(AST_OFS_CTRL, v); chk(v, AST_RST_CTRL);
        finish_test;
    end
endmodule
`default_nettype wire

// File: verification/ast_sram_model.sv
// behavioural asynchronous static ram on the far side of the controller
`timescale 1ns/100ps
`default_nettype none
module ast_sram_model
    import ast_pkg::*;
(
    input wire logic [AST_SRAM_AW-1:0] i_addr, // word address
    input wire logic [AST_SRAM_DW-1:0] i_data, // write data
    output logic [AST_SRAM_DW-1:0] o_data, // read data
    input wire logic i_cs_n, // chip select, active low
    input wire logic i_we_n, // write enable, active low
    input wire logic i_oe_n // output enable, active low
);
    logic [AST_SRAM_DW-1:0] mem [AST_SRAM_WORDS]; // never cleared by any reset
    logic [AST_SRAM_DW-1:0] last = 8'h00;
    // store when strobe or select ends, whichever closes the write first
    wire wr_act = !i_cs_n && !i_we_n;
    always @(negedge wr_act) begin
        mem[i_addr] = i_data;
    end
    // a released bus shows the inverse of the last value, not a stale copy
    always @* begin
        if (!i_cs_n && !i_oe_n && i_we_n) last = mem[i_addr];
        o_data = (!i_cs_n && !i_oe_n && i_we_n) ? last : ~last;
    end
endmodule
`default_nettype wire
